// [include/pdir_pkg.sv]
// Functional notes
// - Package never deeper than shallowest core; any core in C0 keeps package in C0.
// - Package C7 only when all cores reach C7; system agent partly powered off.
// - Governing core state C8 places package in C8.
// - C8 keeps C7 actions, turns internal rails off, lowers input supply band.
// - Governing core state C9 places package in C9.
// - C9 keeps C8 actions and requests input supply at zero volts.
// - Governing core state C10 places package in C10.
// - C10 keeps C9 actions and puts regulator in its lowest power state.
// - All cores at C7 or deeper start dynamic cache flushing.
// - Deep cores flush cache gradually by way groups or at once, per hint.
// - Return to C0 re-enables cache capacity gradually, paced by heuristics.
// - Display configuration caps the deepest permitted package state.
// - Self refresh forced off internally when more than one display is enabled.
// - Multiple displays use the highest native resolution among enabled displays.
// - Non-native resolution picks a limit between native and driven limits.
// - Latency tolerance and interrupt latency limits also constrain package state.
package pdir_pkg;
	typedef enum logic [3:0] {
		PDIR_C0  = 4'h0,
		PDIR_C1  = 4'h1,
		PDIR_C2  = 4'h2,
		PDIR_C3  = 4'h3,
		PDIR_C6  = 4'h4,
		PDIR_C7  = 4'h5,
		PDIR_C7P = 4'h6,
		PDIR_C8  = 4'h7,
		PDIR_C9  = 4'h8,
		PDIR_C10 = 4'h9
	} pdir_pstate_t;

	localparam logic [7:0]  PDIR_CTRL_OFS   = 8'h00;
	localparam logic [7:0]  PDIR_PACE_OFS   = 8'h04;
	localparam logic [7:0]  PDIR_STAT_OFS   = 8'h08;
	localparam logic [7:0]  PDIR_LUT_OFS    = 8'h40;
	localparam int          PDIR_EN_BIT     = 0;
	localparam int          PDIR_LOWV_BIT   = 1;
	localparam int          PDIR_SREF_BIT   = 2;
	localparam int          PDIR_SWLIM_LSB  = 4;
	localparam int          PDIR_VIDCAP_LSB = 8;
	localparam int          PDIR_WAYS_LSB   = 16;
	localparam int          PDIR_BUSY_BIT   = 24;
	localparam logic [31:0] PDIR_CTRL_RST   = 32'h0000_0593;
	localparam logic [15:0] PDIR_PACE_RST   = 16'h0040;
	localparam logic [63:0] PDIR_LUT_RST    = 64'h3333_6666_3456_4666;

	typedef struct packed {
		logic sa_off;
		logic int_rails_off;
		logic vcc_low;
		logic vcc_zero;
		logic reg_lowest;
	} pdir_rail_t;

	typedef struct packed {
		logic [3:0] ltr;
		logic [3:0] irq;
	} pdir_limit_t;

	function automatic logic [3:0] pdir_shallower(input logic [3:0] a, input logic [3:0] b);
		return (a < b) ? a : b;
	endfunction
endpackage

// [verilog/pdir_core_resolve.sv]
`timescale 1ns/1ps
module pdir_core_resolve #(
	parameter int NCORES = 4
) (
	input  wire logic                  clock_in,
	input  wire logic                  sys_rst_in,
	input  wire logic                  ce_in,
	input  wire logic [NCORES*4-1:0]   core_state_in,
	input  wire logic [NCORES-1:0]     hint_in,
	output logic      [3:0]            resolved_out,
	output logic                       bulk_hint_out
);
	logic [3:0] chain [0:NCORES];

	assign chain[0] = pdir_pkg::PDIR_C10;
	for (genvar i = 0; i < NCORES; i++) begin : g_min
		assign chain[i+1] = pdir_pkg::pdir_shallower(chain[i], core_state_in[4*i +: 4]);
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			resolved_out  <= pdir_pkg::PDIR_C0;
			bulk_hint_out <= 1'b0;
		end else if (ce_in) begin
			resolved_out  <= chain[NCORES];
			bulk_hint_out <= &hint_in;
		end
	end
endmodule

// [verilog/pdir_llc_sizer.sv]
`timescale 1ns/1ps
module pdir_llc_sizer #(
	parameter int WAYS = 16,
	parameter int STEP = 4,
	parameter int WW   = $clog2(WAYS + 1)
) (
	input  wire logic          clock_in,
	input  wire logic          sys_rst_in,
	input  wire logic          ce_in,
	input  wire logic          deep_in,
	input  wire logic          bulk_in,
	input  wire logic          wake_in,
	input  wire logic          tick_in,
	output logic      [WW-1:0] ways_out,
	output logic               busy_out
);
	typedef enum logic [1:0] {
		PDIR_SZ_IDLE   = 2'b00,
		PDIR_SZ_SHRINK = 2'b01,
		PDIR_SZ_EXPAND = 2'b10
	} pdir_sz_t;

	localparam logic [WW-1:0] FULL = WW'(WAYS);
	localparam logic [WW-1:0] STP  = WW'(STEP);

	pdir_sz_t state;

	assign busy_out = (state != PDIR_SZ_IDLE);

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state    <= PDIR_SZ_IDLE;
			ways_out <= FULL;
		end else if (ce_in) begin
			unique case (state)
				PDIR_SZ_IDLE: begin
					if (deep_in && ways_out != '0) begin
						state <= PDIR_SZ_SHRINK;
					end else if (wake_in && ways_out != FULL) begin
						state <= PDIR_SZ_EXPAND;
					end
				end
				PDIR_SZ_SHRINK: begin
					if (wake_in) begin
						state <= PDIR_SZ_EXPAND;
					end else if (bulk_in || (tick_in && ways_out <= STP)) begin
						ways_out <= '0;
						state    <= PDIR_SZ_IDLE;
					end else if (tick_in) begin
						ways_out <= ways_out - STP;
					end
				end
				PDIR_SZ_EXPAND: begin
					if (deep_in) begin
						state <= PDIR_SZ_SHRINK;
					end else if (tick_in && ways_out >= FULL - STP) begin
						ways_out <= FULL;
						state    <= PDIR_SZ_IDLE;
					end else if (tick_in) begin
						ways_out <= ways_out + STP;
					end
				end
				default: state <= PDIR_SZ_IDLE;
			endcase
		end
	end

	property p_bulk_flush;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state == PDIR_SZ_SHRINK && bulk_in && !wake_in && ce_in) |=> (ways_out == '0);
	endproperty
	a_bulk_flush: assert property (p_bulk_flush) else $error("bulk flush did not empty cache");

	property p_expand_step;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state == PDIR_SZ_EXPAND && !deep_in && ce_in) |=> (ways_out >= $past(ways_out));
	endproperty
	a_expand_step: assert property (p_expand_step) else $error("cache shrank while expanding");
endmodule

// [verilog/pdir_resolver.sv]
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module pdir_resolver #(
	parameter int NCORES = 4,
	parameter int NDISP  = 3,
	parameter int WAYS   = 16,
	parameter int STEP   = 4
) (
	input  wire logic                     clock_in,
	input  wire logic                     sys_rst_in,
	input  wire logic                     ce_in,
	input  wire logic [7:0]               avs_address_in,
	input  wire logic                     avs_read_in,
	input  wire logic                     avs_write_in,
	input  wire logic [31:0]              avs_writedata_in,
	input  wire logic [3:0]               avs_byteenable_in,
	output logic      [31:0]              avs_readdata_out,
	output logic                          avs_waitrequest_out,
	input  wire logic [NCORES*4-1:0]      core_state_in,
	input  wire logic [NCORES-1:0]        monitor_wait_hint_in,
	input  wire logic [NDISP-1:0]         disp_enable_in,
	input  wire logic [NDISP*2-1:0]       disp_native_class_in,
	input  wire logic [NDISP*2-1:0]       disp_driven_class_in,
	input  wire logic                     video_playback_in,
	input  wire pdir_pkg::pdir_limit_t    limits_in,
	output pdir_pkg::pdir_pstate_t        pkg_state_out,
	output pdir_pkg::pdir_rail_t          rail_req_out,
	output logic      [$clog2(WAYS+1)-1:0] llc_ways_out,
	output logic                          llc_busy_out
);
	localparam int WW = $clog2(WAYS + 1);

	logic [3:0]    core_res;
	logic          bulk_hint;
	logic [31:0]   ctrl;
	logic [15:0]   pace;
	logic [15:0]   pace_cnt;
	logic [3:0]    lut [0:15];
	logic [3:0]    disp_cap_q;
	logic [3:0]    next_disp_cap;
	logic [3:0]    next_pkg;
	logic [1:0]    nat_cls;
	logic [1:0]    drv_cls;
	logic          multi;
	logic          sref_en;
	logic [3:0]    idx_nat;
	logic [3:0]    idx_drv;
	logic [3:0]    lim_nat;
	logic [3:0]    lim_drv;
	logic          tick;
	logic          deep;
	logic          wake;
	logic          sz_busy;
	logic [WW-1:0] sz_ways;
	logic          req;
	logic          ans;

	pdir_core_resolve #(
		.NCORES (NCORES)
	) u_core_resolve (
		.clock_in      (clock_in),
		.sys_rst_in    (sys_rst_in),
		.ce_in         (ce_in),
		.core_state_in (core_state_in),
		.hint_in       (monitor_wait_hint_in),
		.resolved_out  (core_res),
		.bulk_hint_out (bulk_hint)
	);

	// the sizer sees the core view only, not the capped target, so a display
	// cap never stops cache flushing on its own
	assign deep = (core_res >= pdir_pkg::PDIR_C7);
	assign wake = (core_res == pdir_pkg::PDIR_C0);

	pdir_llc_sizer #(
		.WAYS (WAYS),
		.STEP (STEP)
	) u_llc_sizer (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.ce_in      (ce_in),
		.deep_in    (deep),
		.bulk_in    (bulk_hint),
		.wake_in    (wake),
		.tick_in    (tick),
		.ways_out   (sz_ways),
		.busy_out   (sz_busy)
	);

	// heuristic pacing of cache steps
	assign tick = (pace_cnt == 16'h0000);

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pace_cnt <= pdir_pkg::PDIR_PACE_RST;
		end else if (ce_in) begin
			pace_cnt <= tick ? pace : pace_cnt - 16'h0001;
		end
	end

	// display-derived cap
	assign multi   = ($countones(disp_enable_in) > 1);
	assign sref_en = ctrl[pdir_pkg::PDIR_SREF_BIT] & ~multi;
	assign idx_nat = {sref_en, multi, nat_cls};
	assign idx_drv = {sref_en, multi, drv_cls};
	assign lim_nat = lut[idx_nat];
	assign lim_drv = lut[idx_drv];

	always_comb begin
		nat_cls = 2'h0;
		drv_cls = 2'h0;
		for (int i = 0; i < NDISP; i++) begin
			if (disp_enable_in[i] && disp_native_class_in[2*i +: 2] > nat_cls) begin
				nat_cls = disp_native_class_in[2*i +: 2];
			end
			if (disp_enable_in[i] && disp_driven_class_in[2*i +: 2] > drv_cls) begin
				drv_cls = disp_driven_class_in[2*i +: 2];
			end
		end
	end

	always_comb begin
		next_disp_cap = lim_nat;
		if (drv_cls != nat_cls) begin
			// midpoint rounds toward the shallower state, the safe side for latency
			next_disp_cap = 4'((5'(lim_nat) + 5'(lim_drv)) >> 1);
		end
		if (video_playback_in) begin
			next_disp_cap = pdir_pkg::pdir_shallower(next_disp_cap,
				ctrl[pdir_pkg::PDIR_VIDCAP_LSB +: 4]);
		end
		if (disp_enable_in == '0) begin
			next_disp_cap = pdir_pkg::PDIR_C10;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			disp_cap_q <= pdir_pkg::PDIR_C10;
		end else if (ce_in) begin
			disp_cap_q <= next_disp_cap;
		end
	end

	// target package state
	always_comb begin
		next_pkg = core_res;
		next_pkg = pdir_pkg::pdir_shallower(next_pkg, disp_cap_q);
		next_pkg = pdir_pkg::pdir_shallower(next_pkg, limits_in.ltr);
		next_pkg = pdir_pkg::pdir_shallower(next_pkg, limits_in.irq);
		next_pkg = pdir_pkg::pdir_shallower(next_pkg, ctrl[pdir_pkg::PDIR_SWLIM_LSB +: 4]);
		if (next_pkg == pdir_pkg::PDIR_C7P && !ctrl[pdir_pkg::PDIR_LOWV_BIT]) begin
			next_pkg = pdir_pkg::PDIR_C7;
		end
		if (!ctrl[pdir_pkg::PDIR_EN_BIT]) begin
			next_pkg = pdir_pkg::PDIR_C0;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pkg_state_out <= pdir_pkg::PDIR_C0;
			rail_req_out  <= '0;
		end else if (ce_in) begin
			pkg_state_out              <= pdir_pkg::pdir_pstate_t'(next_pkg);
			rail_req_out.sa_off        <= (next_pkg >= pdir_pkg::PDIR_C7);
			rail_req_out.int_rails_off <= (next_pkg >= pdir_pkg::PDIR_C8);
			rail_req_out.vcc_low       <= (next_pkg >= pdir_pkg::PDIR_C8);
			rail_req_out.vcc_zero      <= (next_pkg >= pdir_pkg::PDIR_C9);
			rail_req_out.reg_lowest    <= (next_pkg == pdir_pkg::PDIR_C10);
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			llc_ways_out <= WW'(WAYS);
			llc_busy_out <= 1'b0;
		end else if (ce_in) begin
			llc_ways_out <= sz_ways;
			llc_busy_out <= sz_busy;
		end
	end

	// register bus: one wait cycle, then a single answer cycle
	assign req = avs_read_in | avs_write_in;
	assign ans = req & ~avs_waitrequest_out;

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == pdir_pkg::PDIR_CTRL_OFS) begin
			r = ctrl;
		end else if (a == pdir_pkg::PDIR_PACE_OFS) begin
			r[15:0] = pace;
		end else if (a == pdir_pkg::PDIR_STAT_OFS) begin
			r[3:0]                             = pkg_state_out;
			r[7:4]                             = core_res;
			r[11:8]                            = disp_cap_q;
			r[pdir_pkg::PDIR_WAYS_LSB +: WW]   = llc_ways_out;
			r[pdir_pkg::PDIR_BUSY_BIT]         = llc_busy_out;
		end else if (a[7:6] == pdir_pkg::PDIR_LUT_OFS[7:6] && a[1:0] == 2'h0) begin
			r[3:0] = lut[a[5:2]];
		end
		return r;
	endfunction

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0000_0000;
		end else if (ce_in) begin
			avs_waitrequest_out <= ~(req & avs_waitrequest_out);
			if (avs_read_in && avs_waitrequest_out) begin
				avs_readdata_out <= read_word(avs_address_in);
			end
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl <= pdir_pkg::PDIR_CTRL_RST;
			pace <= pdir_pkg::PDIR_PACE_RST;
		end else if (ce_in && ans && avs_write_in) begin
			if (avs_address_in == pdir_pkg::PDIR_CTRL_OFS) begin
				ctrl <= merge_be(ctrl, avs_writedata_in, avs_byteenable_in);
			end
			if (avs_address_in == pdir_pkg::PDIR_PACE_OFS) begin
				pace <= 16'(merge_be({16'h0000, pace}, avs_writedata_in, avs_byteenable_in));
			end
		end
	end

	// table kept in flops, 16 entries are too few to justify a memory
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < 16; i++) begin
				lut[i] <= pdir_pkg::PDIR_LUT_RST[4*i +: 4];
			end
		end else if (ce_in && ans && avs_write_in && avs_byteenable_in[0]
			&& avs_address_in[7:6] == pdir_pkg::PDIR_LUT_OFS[7:6]
			&& avs_address_in[1:0] == 2'h0) begin
			lut[avs_address_in[5:2]] <= avs_writedata_in[3:0];
		end
	end

	property p_c0_hold;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && core_res == pdir_pkg::PDIR_C0) |=> (pkg_state_out == pdir_pkg::PDIR_C0);
	endproperty
	a_c0_hold: assert property (p_c0_hold) else $error("package left C0 with a core in C0");

	property p_not_deeper;
		@(posedge clock_in) disable iff (sys_rst_in)
		ce_in |=> (pkg_state_out <= $past(core_res));
	endproperty
	a_not_deeper: assert property (p_not_deeper) else $error("package deeper than cores");

	property p_sa_off;
		@(posedge clock_in) disable iff (sys_rst_in)
		rail_req_out.sa_off == (pkg_state_out >= pdir_pkg::PDIR_C7);
	endproperty
	a_sa_off: assert property (p_sa_off) else $error("system agent request mismatch");

	property p_c8_entry;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && core_res == pdir_pkg::PDIR_C8 && next_pkg == core_res)
			|=> (pkg_state_out == pdir_pkg::PDIR_C8) && rail_req_out.int_rails_off
			&& rail_req_out.vcc_low && !rail_req_out.vcc_zero;
	endproperty
	a_c8_entry: assert property (p_c8_entry) else $error("C8 actions wrong");

	property p_c9_rails;
		@(posedge clock_in) disable iff (sys_rst_in)
		(pkg_state_out == pdir_pkg::PDIR_C9) |-> rail_req_out.vcc_zero
			&& rail_req_out.int_rails_off && !rail_req_out.reg_lowest;
	endproperty
	a_c9_rails: assert property (p_c9_rails) else $error("C9 actions wrong");

	property p_c10_rails;
		@(posedge clock_in) disable iff (sys_rst_in)
		rail_req_out.reg_lowest |-> (pkg_state_out == pdir_pkg::PDIR_C10)
			&& rail_req_out.vcc_zero && rail_req_out.sa_off;
	endproperty
	a_c10_rails: assert property (p_c10_rails) else $error("regulator request outside C10");

	property p_sref_multi;
		@(posedge clock_in) disable iff (sys_rst_in)
		multi |-> !idx_nat[3];
	endproperty
	a_sref_multi: assert property (p_sref_multi) else $error("self refresh used with multi display");

	property p_cap;
		@(posedge clock_in) disable iff (sys_rst_in)
		ce_in |=> (pkg_state_out <= $past(disp_cap_q)) && (pkg_state_out <= $past(limits_in.irq));
	endproperty
	a_cap: assert property (p_cap) else $error("package deeper than a limit");

	property p_bus_answer;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && req && avs_waitrequest_out) ##1 ce_in |-> !avs_waitrequest_out ##1 avs_waitrequest_out;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

	property p_c9_entry;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && core_res == pdir_pkg::PDIR_C9 && next_pkg == core_res)
			|=> (pkg_state_out == pdir_pkg::PDIR_C9) && rail_req_out.vcc_zero;
	endproperty
	a_c9_entry: assert property (p_c9_entry) else $error("C9 entry wrong");

	property p_c10_entry;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && core_res == pdir_pkg::PDIR_C10 && next_pkg == core_res)
			|=> (pkg_state_out == pdir_pkg::PDIR_C10) && rail_req_out.reg_lowest;
	endproperty
	a_c10_entry: assert property (p_c10_entry) else $error("C10 entry wrong");

	property p_low_band;
		@(posedge clock_in) disable iff (sys_rst_in)
		rail_req_out.vcc_low |-> rail_req_out.int_rails_off
			&& (pkg_state_out >= pdir_pkg::PDIR_C8);
	endproperty
	a_low_band: assert property (p_low_band) else $error("supply band request outside C8");

	property p_flush_start;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && deep && !sz_busy && sz_ways != '0) |=> sz_busy;
	endproperty
	a_flush_start: assert property (p_flush_start) else $error("cache flush did not start");

	property p_disp_off;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && disp_enable_in == '0) |=> (disp_cap_q == pdir_pkg::PDIR_C10);
	endproperty
	a_disp_off: assert property (p_disp_off) else $error("display off still caps");

	property p_midpoint;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ce_in && disp_enable_in != '0 && !video_playback_in && drv_cls != nat_cls)
			|=> (disp_cap_q >= $past(lim_nat) || disp_cap_q >= $past(lim_drv))
			&& (disp_cap_q <= $past(lim_nat) || disp_cap_q <= $past(lim_drv));
	endproperty
	a_midpoint: assert property (p_midpoint) else $error("non-native cap out of range");
endmodule

// [testbench/pdir_far_model.sv]
`timescale 1ns/1ps
module pdir_far_model #(
	parameter int NCORES = 4,
	parameter int NDISP  = 3
) (
	input  wire logic                  clock_in,
	output logic [NCORES*4-1:0]        core_state_out,
	output logic [NCORES-1:0]          hint_out,
	output logic [NDISP-1:0]           disp_enable_out,
	output logic [NDISP*2-1:0]         native_out,
	output logic [NDISP*2-1:0]         driven_out,
	output logic                       video_out,
	output pdir_pkg::pdir_limit_t      limits_out
);
	initial begin
		core_state_out = '0;
		hint_out = '0;
		disp_enable_out = '0;
		native_out = '0;
		driven_out = '0;
		video_out = 1'b0;
		limits_out = 8'h99;
	end

	// cores change state only just after an edge, as a core would
	task automatic set_cores(input logic [NCORES*4-1:0] st, input logic [NCORES-1:0] h);
		@(posedge clock_in);
		core_state_out <= st;
		hint_out <= h;
	endtask

	task automatic set_disp(input logic [NDISP-1:0] en, input logic [NDISP*2-1:0] nat,
		input logic [NDISP*2-1:0] drv, input logic vid);
		@(posedge clock_in);
		disp_enable_out <= en;
		native_out <= nat;
		driven_out <= drv;
		video_out <= vid;
	endtask

	task automatic set_lim(input logic [7:0] l);
		@(posedge clock_in);
		limits_out <= l;
	endtask
endmodule

// [testbench/pdir_resolver_tb.sv]
`timescale 1ns/1ps
module pdir_resolver_tb;
	logic                   clock_in = 1'b0;
	logic                   sys_rst_in = 1'b1;
	logic [7:0]             avs_address_in = 8'h00;
	logic                   avs_read_in = 1'b0;
	logic                   avs_write_in = 1'b0;
	logic [31:0]            avs_writedata_in = 32'h0;
	logic [31:0]            avs_readdata_out;
	logic                   avs_waitrequest_out;
	logic [15:0]            core_state;
	logic [3:0]             hints;
	logic [2:0]             disp_en;
	logic [5:0]             nat;
	logic [5:0]             drv;
	logic                   video;
	pdir_pkg::pdir_limit_t  limits;
	pdir_pkg::pdir_pstate_t pkg_state_out;
	pdir_pkg::pdir_rail_t   rail_req_out;
	logic [4:0]             llc_ways_out;
	logic                   llc_busy_out;
	logic                   ce = 1'b1;
	int                     fail_count = 0;
	int                     num_checks = 0;
	logic [31:0]            q;

	always #2.5 clock_in = ~clock_in;

	pdir_far_model FAR (.clock_in(clock_in), .core_state_out(core_state), .hint_out(hints),
		.disp_enable_out(disp_en), .native_out(nat), .driven_out(drv), .video_out(video),
		.limits_out(limits));

	pdir_resolver DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .core_state_in(core_state),
		.monitor_wait_hint_in(hints), .disp_enable_in(disp_en),
		.disp_native_class_in(nat), .disp_driven_class_in(drv),
		.video_playback_in(video), .limits_in(limits), .pkg_state_out(pkg_state_out),
		.rail_req_out(rail_req_out), .llc_ways_out(llc_ways_out), .llc_busy_out(llc_busy_out));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low, released only after that edge
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= rd;
		avs_write_in <= !rd;
		do begin
			@(posedge clock_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 50);
		q = avs_readdata_out;
		if (n >= 50) fail_count++;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b1, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic pkg_chk(input logic [3:0] exp);
		repeat (3) @(posedge clock_in);
		chk({28'h0, pkg_state_out}, {28'h0, exp});
	endtask

	// checks each new way count and busy flag until n changes are seen or time runs out
	task automatic track(input int first, input int step, input int n);
		logic [4:0] last;
		int         exp;
		int         k;
		int         t;
		last = llc_ways_out;
		exp = first;
		k = 0;
		t = 0;
		while (k < n && t < 500) begin
			@(posedge clock_in);
			t++;
			if (llc_ways_out !== last) begin
				last = llc_ways_out;
				chk({27'h0, last}, exp);
				// busy while stepping, idle once the last step lands
				chk({31'h0, llc_busy_out}, {31'h0, k != n - 1});
				exp = exp + step;
				k++;
			end
		end
		chk(k, n);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		finish_test();
	end

	logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
	logic [15:0] mixv  [3] = '{16'h9990, 16'h9599, 16'h7999};
	logic [3:0]  mixe  [3] = '{4'h0, 4'h5, 4'h7};
	// display cases: enable, native, driven, video, ctrl, expected cap
	logic [2:0]  den   [7] = '{3'h1, 3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h0};
	logic [5:0]  dnat  [7] = '{6'h03, 6'h08, 6'h08, 6'h00, 6'h03, 6'h00, 6'h00};
	logic [5:0]  ddrv  [7] = '{6'h03, 6'h08, 6'h08, 6'h00, 6'h00, 6'h00, 6'h00};
	logic        dvid  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [31:0] dctl  [7] = '{32'h593, 32'h593, 32'h597, 32'h597, 32'h593, 32'h593, 32'h593};
	logic [3:0]  dexp  [7] = '{4'h4, 4'h4, 4'h4, 4'h6, 4'h5, 4'h5, 4'h9};

	initial begin
		logic [3:0] s;
		repeat (2) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		chk({27'h0, llc_ways_out}, 32'h10);
		chk({28'h0, pkg_state_out}, 32'h0);
		rd_chk(8'h00, 32'h593);
		rd_chk(8'h04, 32'h40);
		bus(1'b0, 8'h20, 32'hffff_ffff);
		rd_chk(8'h20, 32'h0);
		$display("test reset done");

		for (int i = 0; i < 8; i++) begin
			s = codes[i];
			FAR.set_cores({4{s}}, 4'h0);
			pkg_chk(s);
			chk({27'h0, rail_req_out},
				{27'h0, s >= 4'h5, s >= 4'h7, s >= 4'h7, s >= 4'h8, s == 4'h9});
		end
		for (int i = 0; i < 3; i++) begin
			FAR.set_cores(mixv[i], 4'h0);
			pkg_chk(mixe[i]);
		end
		$display("test core resolution done");

		FAR.set_cores(16'h9999, 4'h0);
		FAR.set_lim(8'h89);
		pkg_chk(4'h8);
		FAR.set_lim(8'h97);
		pkg_chk(4'h7);
		FAR.set_lim(8'h99);
		bus(1'b0, 8'h00, 32'h583);
		pkg_chk(4'h8);
		$display("test limits done");

		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 8'h00, dctl[i]);
			FAR.set_disp(den[i], dnat[i], ddrv[i], dvid[i]);
			pkg_chk(dexp[i]);
		end
		bus(1'b0, 8'h4c, 32'h8);
		rd_chk(8'h4c, 32'h8);
		FAR.set_disp(3'h1, 6'h03, 6'h03, 1'b0);
		pkg_chk(4'h8);
		FAR.set_disp(3'h0, 6'h00, 6'h00, 1'b0);
		$display("test display cap done");

		// enable low freezes the package state even though the cores woke
		ce <= 1'b0;
		FAR.set_cores(16'h0000, 4'h0);
		pkg_chk(4'h8);
		ce <= 1'b1;
		pkg_chk(4'h0);
		$display("test clock enable done");

		// the pace counter may need a full old interval before the new one applies
		bus(1'b0, 8'h04, 32'h2);
		FAR.set_cores(16'h9999, 4'h0);
		FAR.set_cores(16'h0000, 4'h0);
		repeat (100) @(posedge clock_in);
		FAR.set_cores(16'h9999, 4'h0);
		track(12, -4, 4);
		FAR.set_cores(16'h0000, 4'h0);
		track(4, 4, 4);
		FAR.set_cores(16'h9999, 4'hf);
		track(0, -16, 1);
		$display("test cache sizing done");
		finish_test();
	end
endmodule
